//--- fuap_pkg.sv
// package: register map, config bit positions and timing constants for power control
// Overview of operation
// [RL1] direct powerdown bits force each block down
// [RL2] disk auto powerdown needs auto config bit 0
// [RL3] sleep needs motors off, idle status, timers expired
// [RL4] idle timer starts when auto powerdown enabled
// [RL5] disabling auto powerdown cancels timer, stays awake
// [RL6] rate register powerdown overrides auto powerdown
// [RL7] reset wake runs full disk reset
// [RL8] register wake resumes with state kept
// [RL9] motor set, status read, data access wake
// [RL10] every wake restarts the idle timer
// [RL11] other accesses keep sleep, data retained
// [RL12] output/rate writes wake only on motor/reset
// [RL13] drive outputs float, step/head/density stay active
// [RL14] host bus pins keep working while asleep
// [RL15] uart auto powerdown needs config bits 4,5
// [RL16] transmitter sleeps when holding and shift empty
// [RL17] receiver sleeps when fifo empty and idle
// [RL18] ring indicator interrupt works while asleep
// [RL19] transmit write or receive edge wakes uart
// [RL20] idle interval counted in own clock cycles
`default_nettype none
package fuap_pkg;
  localparam logic [3:0] FUAP_STAT_A   = 4'h0;  // drive_status_a, read
  localparam logic [3:0] FUAP_STAT_B   = 4'h1;  // drive_status_b, read
  localparam logic [3:0] FUAP_DOUT     = 4'h2;  // drive_output_control
  localparam logic [3:0] FUAP_MSTAT    = 4'h4;  // main status read / rate select write
  localparam logic [3:0] FUAP_DATA     = 4'h5;  // command_data_port
  localparam logic [3:0] FUAP_DIN      = 4'h7;  // drive input read / transfer rate write
  localparam logic [3:0] FUAP_DPWR     = 4'h8;  // direct_powerdown_config
  localparam logic [3:0] FUAP_APWR     = 4'h9;  // auto_power_config
  localparam logic [3:0] FUAP_PSTAT    = 4'ha;  // power state readback
  // direct powerdown bit positions
  localparam int FUAP_DP_FDC = 0;
  localparam int FUAP_DP_U1  = 1;
  localparam int FUAP_DP_U2  = 2;
  localparam int FUAP_DP_PP  = 3;
  // auto power bit positions
  localparam int FUAP_AP_FDC = 0;
  localparam int FUAP_AP_U1  = 4;
  localparam int FUAP_AP_U2  = 5;
  // output control fields: motor enables [7:4], reset low at bit 2
  localparam int FUAP_DO_RSTN = 2;
  // rate select: software reset bit 7, powerdown bit 6
  localparam int FUAP_RS_RST = 7;
  localparam int FUAP_RS_PD  = 6;
  localparam logic [7:0] FUAP_MSTAT_IDLE = 8'h80;
  localparam logic [7:0] FUAP_DOUT_RST   = 8'h04;
  localparam int FUAP_IDLE_MS  = 10;
  localparam int FUAP_CLK_KHZ  = 100000;
  localparam int FUAP_IDLE_CYC = FUAP_IDLE_MS * FUAP_CLK_KHZ;  // see [RL20]
  localparam int FUAP_RST_CYC  = 4;  // length of full reset pulse
  typedef enum logic [2:0] {
    FUAP_AWAKE = 3'b001,
    FUAP_ASLP  = 3'b010,
    FUAP_RSLP  = 3'b100
  } fuap_st_t;
endpackage
`default_nettype wire

//--- fuap_top.sv
// module: disk controller and uart power management with register port
`default_nettype none
module fuap_top
  import fuap_pkg::*;
#(
  parameter int IDLE_CYC = FUAP_IDLE_CYC  // 10 ms at 100 MHz
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,          // system reset pin, synchronous
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // core status inputs
  input  wire logic [7:0] main_status_i,  // main_controller_status from core
  input  wire logic       fdc_int_i,
  input  wire logic       head_unload_done_i,
  input  wire logic [7:0] drive_status_a_i,
  input  wire logic [7:0] drive_status_b_i,
  input  wire logic [7:0] drive_input_i,
  input  wire logic [7:0] data_rd_i,
  // core-side drive outputs
  input  wire logic       step_dir_i,
  input  wire logic       step_pulse_i,
  input  wire logic       head_sel_i,
  input  wire logic [1:0] density_i,
  input  wire logic [1:0] drive_sel_i,
  input  wire logic       write_bits_i,
  input  wire logic       write_gate_i,
  // drive pins
  output logic      [3:0] motor_on_out_o,
  output logic      [3:0] motor_on_oe_o,
  output logic      [1:0] drive_select_out_o,
  output logic            drive_select_oe_o,
  output logic            write_bitstream_out_o,
  output logic            write_gate_out_o,
  output logic            write_oe_o,
  output logic            step_direction_out_o,
  output logic            step_pulse_out_o,
  output logic            head_select_out_o,
  output logic      [1:0] density_select_out_o,
  // core controls
  output logic            fdc_reset_o,     // full reset sequence pulse
  output logic            fdc_clk_en_o,    // core clock gate enable
  output logic      [7:0] rate_wr_o,       // retained rate select
  output logic      [7:0] xfer_rate_o,     // retained transfer rate
  output logic            data_wr_o,
  output logic      [7:0] data_wdata_o,
  // uart status inputs, index 0 uart1
  input  wire logic [1:0] tx_hold_empty_i,
  input  wire logic [1:0] tx_shift_empty_i,
  input  wire logic [1:0] rx_fifo_empty_i,
  input  wire logic [1:0] rx_idle_i,
  input  wire logic [1:0] tx_buf_wr_i,
  input  wire logic [1:0] serial_receive_in_i,
  input  wire logic [1:0] ring_indicator_in_i,
  output logic      [1:0] tx_pd_o,
  output logic      [1:0] rx_pd_o,
  output logic      [1:0] ring_irq_o,
  output logic            par_pd_o
);
  typedef struct packed {
    fuap_st_t    st;        // disk controller power state
    logic [31:0] tmr;       // idle countdown
    logic [7:0]  dout;      // drive output control
    logic [7:0]  rate;      // rate select
    logic [7:0]  xrate;     // transfer rate
    logic [7:0]  dpwr;      // direct powerdown config
    logic [7:0]  apwr;      // auto power config
    logic [7:0]  rdata;
    logic [2:0]  rcnt;      // reset pulse counter
    logic [1:0]  txpd;
    logic [1:0]  rxpd;
    logic [1:0]  rxd;       // last receive level
    logic [1:0]  ri;        // last ring level
    logic [1:0]  rirq;
  } fuap_state_t;

  fuap_state_t st_ff;
  fuap_state_t nxt_st;

  logic wake_acc;   // qualifying waking access
  logic sw_rst;     // software reset write
  logic cond_ok;    // entry conditions apart from timer

  // access decode for waking
  always_comb begin
    sw_rst = (wr_i && addr_i == FUAP_DOUT && !wdata_i[FUAP_DO_RSTN])
          || (wr_i && addr_i == FUAP_MSTAT && wdata_i[FUAP_RS_RST]);  // see [RL12]
    wake_acc = (wr_i && addr_i == FUAP_DOUT && |wdata_i[7:4])          // see [RL9]
            || (rd_i && addr_i == FUAP_MSTAT)
            || ((rd_i || wr_i) && addr_i == FUAP_DATA);
    cond_ok = (st_ff.dout[7:4] == 4'h0) && (main_status_i == FUAP_MSTAT_IDLE)
            && !fdc_int_i && head_unload_done_i;                         // see [RL3]
  end

  // next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rdata = 8'h00;
    if (nxt_st.rcnt != 3'h0) begin
      nxt_st.rcnt = st_ff.rcnt - 3'h1;
    end
    // register writes are retained even while asleep
    if (wr_i) begin  // see [RL11]
      unique case (addr_i)
        FUAP_DOUT:  nxt_st.dout  = wdata_i;
        FUAP_MSTAT: nxt_st.rate  = wdata_i;
        FUAP_DIN:   nxt_st.xrate = wdata_i;
        FUAP_DPWR:  nxt_st.dpwr  = wdata_i;
        FUAP_APWR:  nxt_st.apwr  = wdata_i;
        default: ;
      endcase
    end
    // reads return true status whatever the power state
    if (rd_i) begin
      unique case (addr_i)
        FUAP_STAT_A: nxt_st.rdata = drive_status_a_i;
        FUAP_STAT_B: nxt_st.rdata = drive_status_b_i;
        FUAP_DOUT:   nxt_st.rdata = st_ff.dout;
        FUAP_MSTAT:  nxt_st.rdata = main_status_i;
        FUAP_DATA:   nxt_st.rdata = data_rd_i;
        FUAP_DIN:    nxt_st.rdata = drive_input_i;
        FUAP_DPWR:   nxt_st.rdata = st_ff.dpwr;
        FUAP_APWR:   nxt_st.rdata = st_ff.apwr;
        FUAP_PSTAT:  nxt_st.rdata = {3'h0, st_ff.st, st_ff.tmr == 32'h0, 1'b0};
        default:     nxt_st.rdata = 8'h00;
      endcase
    end
    // idle timer: reloaded on wake and while disabled
    if (!st_ff.apwr[FUAP_AP_FDC]) begin
      nxt_st.tmr = IDLE_CYC;  // see [RL5]
    end else if (st_ff.tmr != 32'h0) begin
      nxt_st.tmr = st_ff.tmr - 32'h1;  // see [RL4]
    end
    unique case (st_ff.st)
      FUAP_AWAKE: begin
        if (wr_i && addr_i == FUAP_MSTAT && wdata_i[FUAP_RS_PD]) begin
          nxt_st.st = FUAP_RSLP;
        end else if (st_ff.apwr[FUAP_AP_FDC] && cond_ok && st_ff.tmr == 32'h0
                     && !wake_acc) begin
          nxt_st.st = FUAP_ASLP;  // see [RL2]
        end
      end
      FUAP_ASLP: begin
        if (wr_i && addr_i == FUAP_MSTAT && wdata_i[FUAP_RS_PD]) begin
          nxt_st.st = FUAP_RSLP;  // see [RL6]
        end else if (!st_ff.apwr[FUAP_AP_FDC] || wake_acc || sw_rst) begin
          nxt_st.st  = FUAP_AWAKE;  // see [RL8]
          nxt_st.tmr = IDLE_CYC;    // see [RL10]
        end
      end
      FUAP_RSLP: begin
        if (wake_acc || sw_rst) begin
          nxt_st.st  = FUAP_AWAKE;  // auto mode resumes afterwards
          nxt_st.tmr = IDLE_CYC;
          nxt_st.rate[FUAP_RS_PD] = 1'b0;
        end
      end
      default: nxt_st.st = FUAP_AWAKE;
    endcase
    if (sw_rst) begin
      nxt_st.rcnt = 3'(FUAP_RST_CYC);  // see [RL7]
    end
    // uart auto powerdown
    for (int i = 0; i < 2; i++) begin
      nxt_st.rxd[i] = serial_receive_in_i[i];
      nxt_st.ri[i]  = ring_indicator_in_i[i];
      // ring change raises irq regardless of power state
      nxt_st.rirq[i] = ring_indicator_in_i[i] != st_ff.ri[i];  // see [RL18]
      if (!st_ff.apwr[FUAP_AP_U1 + i]) begin
        nxt_st.txpd[i] = 1'b0;  // see [RL15]
        nxt_st.rxpd[i] = 1'b0;
      end else begin
        if (tx_buf_wr_i[i]) begin
          nxt_st.txpd[i] = 1'b0;  // see [RL19]
        end else if (tx_hold_empty_i[i] && tx_shift_empty_i[i]) begin
          nxt_st.txpd[i] = 1'b1;  // see [RL16]
        end
        if (serial_receive_in_i[i] != st_ff.rxd[i]) begin
          nxt_st.rxpd[i] = 1'b0;  // see [RL19]
        end else if (rx_fifo_empty_i[i] && rx_idle_i[i]) begin
          nxt_st.rxpd[i] = 1'b1;  // see [RL17]
        end
      end
    end
  end

  // state register; hardware reset gives the full reset sequence
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff       <= '0;
      st_ff.st    <= FUAP_AWAKE;
      st_ff.dout  <= FUAP_DOUT_RST;
      st_ff.tmr   <= IDLE_CYC;  // follow the parameter, not the package default
      st_ff.rcnt  <= 3'(FUAP_RST_CYC);  // see [RL7]
      st_ff.rxd   <= 2'h3;
    end else begin
      st_ff <= nxt_st;
    end
  end

  logic fdc_down;
  // direct powerdown acts independent of auto state
  assign fdc_down = (st_ff.st != FUAP_AWAKE) || st_ff.dpwr[FUAP_DP_FDC];  // see [RL1]

  // drive pins: motor, select, write float when down; others stay active
  assign motor_on_out_o        = ~st_ff.dout[7:4];
  assign motor_on_oe_o         = {4{!fdc_down}};  // see [RL13]
  assign drive_select_out_o    = drive_sel_i;
  assign drive_select_oe_o     = !fdc_down;
  assign write_bitstream_out_o = write_bits_i;
  assign write_gate_out_o      = write_gate_i;
  assign write_oe_o            = !fdc_down;
  assign step_direction_out_o  = step_dir_i;
  assign step_pulse_out_o      = step_pulse_i;
  assign head_select_out_o     = head_sel_i;
  assign density_select_out_o  = density_i;
  // host bus port never gated by powerdown
  assign rdata_o      = st_ff.rdata;  // see [RL14]
  assign fdc_reset_o  = st_ff.rcnt != 3'h0;
  assign fdc_clk_en_o = !fdc_down;
  assign rate_wr_o    = st_ff.rate;
  assign xfer_rate_o  = st_ff.xrate;
  assign data_wr_o    = wr_i && addr_i == FUAP_DATA;
  assign data_wdata_o = wdata_i;
  assign tx_pd_o      = st_ff.txpd | {st_ff.dpwr[FUAP_DP_U2], st_ff.dpwr[FUAP_DP_U1]};
  assign rx_pd_o      = st_ff.rxpd | {st_ff.dpwr[FUAP_DP_U2], st_ff.dpwr[FUAP_DP_U1]};
  assign ring_irq_o   = st_ff.rirq;
  assign par_pd_o     = st_ff.dpwr[FUAP_DP_PP];

  // assertions
  wake_stat_a: assert property (@(posedge clk_i) disable iff (rst_i)  // see [RL9]
    (st_ff.st == FUAP_ASLP && rd_i && addr_i == FUAP_MSTAT) |=> st_ff.st == FUAP_AWAKE)
    else $error("status read did not wake");
  sleep_cond_a: assert property (@(posedge clk_i) disable iff (rst_i)  // see [RL3]
    (st_ff.st == FUAP_AWAKE) ##1 (st_ff.st == FUAP_ASLP) |-> $past(cond_ok))
    else $error("sleep without conditions");
  auto_off_a: assert property (@(posedge clk_i) disable iff (rst_i)  // see [RL5]
    !st_ff.apwr[FUAP_AP_FDC] |=> st_ff.st != FUAP_ASLP)
    else $error("auto sleep while disabled");
  tmr_reload_a: assert property (@(posedge clk_i) disable iff (rst_i)  // see [RL10]
    (st_ff.st == FUAP_ASLP ##1 st_ff.st == FUAP_AWAKE) |-> st_ff.tmr == IDLE_CYC)
    else $error("timer not restarted");
  pins_float_a: assert property (@(posedge clk_i) disable iff (rst_i)  // see [RL13]
    (st_ff.st != FUAP_AWAKE) |-> !write_oe_o && !drive_select_oe_o && motor_on_oe_o == 4'h0)
    else $error("drive pins driven asleep");
  dout_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)  // see [RL11]
    (st_ff.st == FUAP_ASLP && wr_i && addr_i == FUAP_DOUT && wdata_i[7:4] == 4'h0
     && wdata_i[FUAP_DO_RSTN]) |=> st_ff.st == FUAP_ASLP && st_ff.dout == $past(wdata_i))
    else $error("plain write woke or lost");
  rate_pd_a: assert property (@(posedge clk_i) disable iff (rst_i)  // see [RL6]
    (wr_i && addr_i == FUAP_MSTAT && wdata_i[FUAP_RS_PD] && !wdata_i[FUAP_RS_RST])
    |=> st_ff.st == FUAP_RSLP)
    else $error("rate powerdown ignored");
  tx_sleep_a: assert property (@(posedge clk_i) disable iff (rst_i)  // see [RL16]
    (st_ff.apwr[FUAP_AP_U1] && tx_hold_empty_i[0] && tx_shift_empty_i[0] && !tx_buf_wr_i[0])
    |=> tx_pd_o[0])
    else $error("transmitter stayed up");
  swrst_a: assert property (@(posedge clk_i) disable iff (rst_i)  // see [RL7]
    sw_rst |=> fdc_reset_o [*4])
    else $error("reset pulse short");
endmodule
`default_nettype wire

//--- fuap_core_model.sv
// model: disk core and drive status levels seen by the power control block
`default_nettype none
module fuap_core_model (
  input  wire logic       busy_i,              // core in mid-command
  input  wire logic [3:0] motor_on_i,          // active-low motor pins
  output logic      [7:0] main_status_o,
  output logic            fdc_int_o,
  output logic            head_unload_done_o,
  output logic      [7:0] drive_status_a_o,
  output logic      [7:0] drive_status_b_o,
  output logic      [7:0] drive_input_o,
  output logic      [7:0] data_rd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // a busy core is not ready, raises its interrupt and keeps the head loaded
  assign main_status_o      = busy_i ? 8'h10 : 8'h80;
  assign fdc_int_o          = busy_i;
  assign head_unload_done_o = !busy_i;
  // motor pins folded into status b so its read is not a constant
  assign drive_status_a_o   = 8'h5a;
  assign drive_status_b_o   = {4'ha, motor_on_i};
  assign drive_input_o      = 8'h3c;
  assign data_rd_o          = 8'hc3;
endmodule
`default_nettype wire

//--- testbench.sv
// testbench: self-checking bench for disk and uart power management
`default_nettype none
module testbench
  import fuap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int IDLE = 20;  // short idle count keeps the run brief
  typedef struct packed {
    logic [3:0] a;
    logic [7:0] e;
  } fuap_row_t;
  logic       clk_i, rst_i, wr_i, rd_i, busy, fire, fdc_int_i, head_unload_done_i;
  logic [3:0] addr_i, motor_on_out_o, motor_on_oe_o;
  logic [7:0] wdata_i, rdata_o, main_status_i, drive_status_a_i, drive_status_b_i;
  logic [7:0] drive_input_i, data_rd_i, rate_wr_o, xfer_rate_o, data_wdata_o;
  logic [1:0] density_i, drive_sel_i, drive_select_out_o, density_select_out_o;
  logic       step_dir_i, step_pulse_i, head_sel_i, write_bits_i, write_gate_i;
  logic       drive_select_oe_o, write_bitstream_out_o, write_gate_out_o, write_oe_o;
  logic       step_direction_out_o, step_pulse_out_o, head_select_out_o;
  logic       fdc_reset_o, fdc_clk_en_o, data_wr_o, par_pd_o;
  logic [1:0] tx_hold_empty_i, tx_shift_empty_i, rx_fifo_empty_i, rx_idle_i, tx_buf_wr_i;
  logic [1:0] serial_receive_in_i, ring_indicator_in_i, tx_pd_o, rx_pd_o, ring_irq_o;
  int         failures, compares;
  logic [7:0] dw;        // last data port write seen by the core
  fuap_row_t  rows [7];  // reads while awake: address and expected data
  fuap_row_t  wk [3];    // waking accesses: first a read, then writes
  // design under test
  fuap_top #(.IDLE_CYC(IDLE)) dut (
    .clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .main_status_i, .fdc_int_i,
    .head_unload_done_i, .drive_status_a_i, .drive_status_b_i, .drive_input_i, .data_rd_i,
    .step_dir_i, .step_pulse_i, .head_sel_i, .density_i, .drive_sel_i, .write_bits_i,
    .write_gate_i, .motor_on_out_o, .motor_on_oe_o, .drive_select_out_o, .drive_select_oe_o,
    .write_bitstream_out_o, .write_gate_out_o, .write_oe_o, .step_direction_out_o,
    .step_pulse_out_o, .head_select_out_o, .density_select_out_o, .fdc_reset_o,
    .fdc_clk_en_o, .rate_wr_o, .xfer_rate_o, .data_wr_o, .data_wdata_o, .tx_hold_empty_i,
    .tx_shift_empty_i, .rx_fifo_empty_i, .rx_idle_i, .tx_buf_wr_i, .serial_receive_in_i,
    .ring_indicator_in_i, .tx_pd_o, .rx_pd_o, .ring_irq_o, .par_pd_o);
  // disk core and drive on the far side
  fuap_core_model core (.busy_i(busy), .motor_on_i(motor_on_out_o),
    .main_status_o(main_status_i), .fdc_int_o(fdc_int_i),
    .head_unload_done_o(head_unload_done_i), .drive_status_a_o(drive_status_a_i),
    .drive_status_b_o(drive_status_b_i), .drive_input_o(drive_input_i),
    .data_rd_o(data_rd_i));
  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // capture data port writes passed through to the core
  always @(posedge clk_i) begin
    if (data_wr_o) begin
      dw = data_wdata_o;
    end
  end
  // compare and count
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // one strobe cycle; read data is sampled in the cycle after it
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= w;
    rd_i    <= !w;
    @(posedge clk_i);
    wr_i    <= 1'b0;
    rd_i    <= 1'b0;
    #1;
  endtask
  // power state readback, one-hot in bits 4:2
  task automatic st(input logic [2:0] e);
    bus(1'b0, FUAP_PSTAT, 8'h00);
    chk("state", {5'h0, rdata_o[4:2]}, {5'h0, e});
  endtask
  // long enough for the idle count to run out
  task automatic nap();
    repeat (IDLE + 10) @(posedge clk_i);
  endtask
  task automatic give_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    failures++;
    give_verdict();
  end
  // main sequence
  initial begin
    {wr_i, rd_i, busy, addr_i, wdata_i} = '0;
    {step_dir_i, step_pulse_i, head_sel_i, density_i, drive_sel_i} = '0;
    {write_bits_i, write_gate_i, tx_buf_wr_i} = '0;
    {tx_hold_empty_i, tx_shift_empty_i, rx_fifo_empty_i, rx_idle_i} = '0;
    {serial_receive_in_i, ring_indicator_in_i} = 4'hc;
    rst_i = 1'b1;
    rows = '{'{FUAP_STAT_A, 8'h5a}, '{FUAP_STAT_B, 8'haf}, '{FUAP_DIN, 8'h3c},
      '{FUAP_MSTAT, 8'h80}, '{FUAP_DATA, 8'hc3}, '{4'h3, 8'h00}, '{4'hb, 8'h00}};
    wk = '{'{FUAP_MSTAT, 8'h00}, '{FUAP_DATA, 8'h11}, '{FUAP_DOUT, 8'h14}};
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1 chk("fdc_reset", {7'h0, fdc_reset_o}, 8'h01);
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, rows[i].a, 8'h00);
      chk("rdata", rdata_o, rows[i].e);
    end
    nap();
    st(3'b001);
    {step_dir_i, step_pulse_i, head_sel_i, density_i} <= 5'h1f;
    bus(1'b1, FUAP_APWR, 8'h01);
    nap();
    st(3'b010);
    chk("oe", {motor_on_oe_o, drive_select_oe_o, write_oe_o, fdc_clk_en_o, 1'b0}, 8'h00);
    chk("active", {3'h0, step_direction_out_o, step_pulse_out_o, head_select_out_o,
      density_select_out_o}, 8'h1f);
    // accesses that must leave the controller asleep
    bus(1'b0, FUAP_STAT_A, 8'h00);
    chk("status_a", rdata_o, 8'h5a);
    bus(1'b1, FUAP_DIN, 8'h02);
    chk("xfer_rate", xfer_rate_o, 8'h02);
    bus(1'b1, FUAP_DOUT, 8'h04);
    st(3'b010);
    // each waking access, then sleep again after a fresh idle count
    for (int i = 0; i < 3; i++) begin
      bus(i > 0, wk[i].a, wk[i].e);
      st(3'b001);
      bus(1'b1, FUAP_DOUT, 8'h04);
      nap();
      st(3'b010);
    end
    chk("data_wr", dw, 8'h11);
    // a busy core keeps it awake
    busy <= 1'b1;
    bus(1'b0, FUAP_MSTAT, 8'h00);
    nap();
    st(3'b001);
    busy <= 1'b0;
    nap();
    // rate powerdown over auto sleep, woken by the rate reset bit
    bus(1'b1, FUAP_MSTAT, 8'h40);
    st(3'b100);
    bus(1'b1, FUAP_MSTAT, 8'h80);
    chk("fdc_reset", {7'h0, fdc_reset_o}, 8'h01);
    nap();
    st(3'b010);
    bus(1'b1, FUAP_APWR, 8'h00);
    nap();
    st(3'b001);
    bus(1'b1, FUAP_DOUT, 8'h00);
    chk("fdc_reset", {7'h0, fdc_reset_o}, 8'h01);
    bus(1'b1, FUAP_DOUT, 8'h04);
    // uart auto powerdown
    {tx_hold_empty_i, tx_shift_empty_i, rx_fifo_empty_i, rx_idle_i} <= 8'hff;
    repeat (3) @(posedge clk_i);
    #1 chk("uart_pd", {4'h0, tx_pd_o, rx_pd_o}, 8'h00);
    bus(1'b1, FUAP_APWR, 8'h30);
    repeat (2) @(posedge clk_i);
    #1 chk("uart_pd", {4'h0, tx_pd_o, rx_pd_o}, 8'h0f);
    tx_hold_empty_i[0]     <= 1'b0;
    rx_idle_i[1]           <= 1'b0;
    tx_buf_wr_i[0]         <= 1'b1;
    serial_receive_in_i[1] <= 1'b0;
    @(posedge clk_i);
    tx_buf_wr_i[0] <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1 chk("uart_pd", {4'h0, tx_pd_o, rx_pd_o}, 8'h09);
    ring_indicator_in_i <= 2'b10;
    fire = 1'b0;
    repeat (4) begin
      @(posedge clk_i);
      #1 fire = fire | ring_irq_o[1];
    end
    chk("ring_irq", {7'h0, fire}, 8'h01);
    // direct powerdown bits
    bus(1'b1, FUAP_APWR, 8'h00);
    bus(1'b1, FUAP_DPWR, 8'h0f);
    chk("direct", {2'h0, par_pd_o, fdc_clk_en_o, tx_pd_o, rx_pd_o}, 8'h2f);
    bus(1'b1, FUAP_DPWR, 8'h00);
    chk("direct", {2'h0, par_pd_o, fdc_clk_en_o, tx_pd_o, rx_pd_o}, 8'h10);
    give_verdict();
  end
endmodule
`default_nettype wire
